// file: logic/dis_pkg.sv
`default_nettype none
package dis_pkg;
   localparam int CLK_HZ      = 40_000_000;
   localparam int SCAN_US     = 900;
   localparam int MS_US       = 1000;
   localparam int SCAN_CYC    = SCAN_US * (CLK_HZ / 1_000_000);
   localparam int MS_CYC      = MS_US * (CLK_HZ / 1_000_000);
   localparam int NCH         = 32;
   localparam int DEB_W       = 10;
   localparam int DEB_MAX_MS  = 1000;
   localparam int MS_PER_S    = 1000;
   localparam int DBL_TMR_W   = 18;
   localparam int BCD_W       = 27;
   localparam int BCD_DIGITS  = 8;
   localparam logic [9:0]  AGE_SAT   = 10'h3FF;
   localparam logic [7:0]  CHAT_SAT  = 8'hFF;
   localparam logic [31:0] TIME_RST  = 32'h0;
   localparam logic [4:0]  LAST_CH   = 5'h1F;
   localparam logic [1:0]  FORM_A    = 2'h0;
   localparam logic [1:0]  FORM_B    = 2'h1;
   localparam logic [1:0]  FORM_C    = 2'h2;
   localparam logic        EV_SINGLE = 1'h0;
   localparam logic        EV_DOUBLE = 1'h1;
   typedef enum logic [1:0] {
      PT_SINGLE = 2'h0,
      PT_DOUBLE = 2'h1,
      PT_BCD    = 2'h2,
      PT_COUNT  = 2'h3
   } dis_ptype_type;
   typedef enum logic [2:0] {
      W_IDLE  = 3'h1,
      W_RUN   = 3'h2,
      W_DRAIN = 3'h4
   } dis_walk_type;
endpackage
`default_nettype wire

// file: logic/dis_timebase.sv
`default_nettype none
module dis_timebase #(
   parameter int SCAN_CYC = dis_pkg::SCAN_CYC,
   parameter int MS_CYC   = dis_pkg::MS_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // ticks and time
   output logic             scan_tick,
   output logic             ms_tick,
   output logic [31:0]      ms_now
);
   logic [15:0] sc_reg, sc_next, mc_reg, mc_next;
   logic        scan_next, ms_next;
   logic [31:0] now_next;

   always_comb begin
      scan_next = (sc_reg == 16'(SCAN_CYC - 1));
      ms_next   = (mc_reg == 16'(MS_CYC - 1));
      sc_next   = scan_next ? 16'h0000 : sc_reg + 16'h0001;
      mc_next   = ms_next ? 16'h0000 : mc_reg + 16'h0001;
      now_next  = ms_tick ? ms_now + 32'h0000_0001 : ms_now;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sc_reg    <= 16'h0000;
         mc_reg    <= 16'h0000;
         scan_tick <= 1'b0;
         ms_tick   <= 1'b0;
         ms_now    <= dis_pkg::TIME_RST;
      end else begin
         sc_reg    <= sc_next;
         mc_reg    <= mc_next;
         scan_tick <= scan_next;
         ms_tick   <= ms_next;
         ms_now    <= now_next;
      end
   end
endmodule
`default_nettype wire

// file: logic/dis_cnt_mem.sv
`default_nettype none
module dis_cnt_mem (
   // clock
   input  wire logic        clk,
   // scan side
   input  wire logic [4:0]  rd_addr,
   input  wire logic [4:0]  wr_addr,
   input  wire logic        we_live,
   input  wire logic [31:0] wd_live,
   input  wire logic        we_frz,
   input  wire logic [31:0] wd_frz,
   output logic      [31:0] rd_live,
   // host side, bit 5 picks the frozen bank
   input  wire logic [5:0]  host_addr,
   output logic      [31:0] host_data
);
   logic [31:0] live_mem [32];
   logic [31:0] frz_mem  [32];

   // no reset: live contents are cleared by the first scan after reset, the frozen bank is not
   always_ff @(posedge clk) begin
      if (we_live) begin
         live_mem[wr_addr] <= wd_live;
      end
      if (we_frz) begin
         frz_mem[wr_addr] <= wd_frz;
      end
      rd_live   <= live_mem[rd_addr];
      host_data <= host_addr[5] ? frz_mem[host_addr[4:0]] : live_mem[host_addr[4:0]];
   end
endmodule
`default_nettype wire

// file: logic/dis_scanner.sv
// Overview of operation
// [R1] thirty-two inputs in two groups of sixteen
// [R2] sample every input once per 0.9 ms
// [R3] optional per-input inversion before all processing
// [R4] per-input debounce 0 to 1000 ms
// [R5] pulses wider than 3 ms are caught
// [R6] too many changes per window disables input
// [R7] four point types per input
// [R8] BCD inputs decode up to eight digits
// [R9] double-bit report waits 0 to 255 s
// [R10] single and double points may record events
// [R11] event carries point, type and time
// [R12] event time 1 ms resolution and error
// [R13] 32-bit counters wrap to zero
// [R14] counters support Form A, B, C contacts
// [R15] count rising edges or both edges
// [R16] freeze captures counters, clear zeroes them
// [R17] accept change only after stable debounce time
// [R18] disabled input gives no events or counts
`default_nettype none
module dis_scanner #(
   parameter int SCAN_CYC = dis_pkg::SCAN_CYC,
   parameter int MS_CYC   = dis_pkg::MS_CYC
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          nrst,
   // field contacts
   input  wire logic [31:0]   field_in,
   // configuration
   input  wire logic [31:0]   cfg_invert,
   input  wire logic [63:0]   cfg_type,
   input  wire logic [63:0]   cfg_form,
   input  wire logic [31:0]   cfg_both_edges,
   input  wire logic [31:0]   cfg_event_en,
   input  wire logic [319:0]  cfg_deb_ms,
   input  wire logic [7:0]    cfg_dbl_sec,
   input  wire logic [15:0]   cfg_chat_win_ms,
   input  wire logic [7:0]    cfg_chat_limit,
   input  wire logic [31:0]   chat_reenable,
   // counter commands and readback
   input  wire logic          cmd_freeze,
   input  wire logic          cmd_clear,
   input  wire logic [5:0]    cnt_rd_addr,
   output logic      [31:0]   cnt_rd_data,
   // point state
   output logic      [31:0]   point_level,
   output logic      [31:0]   chat_disabled,
   output logic      [26:0]   bcd_value,
   output logic               bcd_error,
   // event_time_tag_record
   output logic               ev_valid,
   output logic      [4:0]    ev_point,
   output logic               ev_kind,
   output logic      [1:0]    ev_state,
   output logic      [31:0]   ev_time
);
   logic        scan_tick, ms_tick;
   logic [31:0] ms_now, rd_live, wd_live;
   dis_pkg::dis_walk_type st_reg, st_next;
   logic [4:0]  idx_reg, idx_next, pidx_reg, pidx_next;
   logic [31:0] lvl_next, cand_reg, cand_next;
   logic        frz_pend_reg, frz_pend_next, clr_pend_reg, clr_pend_next;
   logic        frz_app_reg, frz_app_next, clr_app_reg, clr_app_next;
   logic        pv_reg, pv_next, pinc_reg, pinc_next;
   logic        evv_next, evk_next;
   logic [4:0]  evp_next;
   logic [1:0]  evs_next;
   logic [31:0] evt_next;
   logic [26:0] bcd_next;
   logic        bcd_err_next;
   logic [1:0]  dbl_last_reg [16];
   logic [1:0]  dbl_last_next [16];
   logic [15:0] dbl_pend_reg, dbl_pend_next, dbl_load, dbl_zero;
   logic [31:0] dbl_time_reg [16];
   logic [31:0] dbl_time_next [16];
   logic [9:0]  age_reg [32];
   logic [31:0] age_clr, acc_vec;
   logic [15:0] win_reg, win_next;
   logic        chat_on, win_end;
   // per-channel working values
   logic        raw, mate, accept;
   logic [1:0]  form, dnew;
   logic [3:0]  pair;
   logic [9:0]  deb;
   logic [31:0] tag, bcd_bits;
   dis_pkg::dis_ptype_type ptype;
   logic [26:0] bcd_acc;
   logic [3:0]  dig;
   int          k;

   dis_timebase #(.SCAN_CYC(SCAN_CYC), .MS_CYC(MS_CYC)) u_tb (
      .clk       (clk),
      .nrst      (nrst),
      .scan_tick (scan_tick),
      .ms_tick   (ms_tick),
      .ms_now    (ms_now)
   );

   // [R13] live counters, wrap comes free from the 32-bit add
   assign wd_live = clr_app_reg ? 32'h0000_0000 : rd_live + {31'h0, pinc_reg};

   // [R16] frozen bank takes pre-increment count
   dis_cnt_mem u_mem (
      .clk       (clk),
      .rd_addr   (idx_reg),
      .wr_addr   (pidx_reg),
      .we_live   (pv_reg),
      .wd_live   (wd_live),
      .we_frz    (pv_reg & frz_app_reg),
      .wd_frz    (rd_live),
      .rd_live   (rd_live),
      .host_addr (cnt_rd_addr),
      .host_data (cnt_rd_data)
   );

   // chatter observation window in ms
   assign chat_on = (cfg_chat_win_ms != 16'h0000);
   assign win_end = chat_on && ms_tick && (win_reg >= cfg_chat_win_ms - 16'h0001);

   always_comb begin
      win_next = win_end ? 16'h0000 : (ms_tick ? win_reg + 16'h0001 : win_reg);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         win_reg <= 16'h0000;
      end else begin
         win_reg <= win_next;
      end
   end

   // per-channel age, chatter and pair timers
   for (genvar i = 0; i < dis_pkg::NCH; i++) begin : g_ch
      logic [7:0] chat_reg, chat_next;
      logic       dis_next;
      logic [9:0] age_next;
      always_comb begin
         // [R5] ms age, so 3 ms pulses survive
         age_next  = age_clr[i] ? 10'h000 :
                     ((ms_tick && age_reg[i] != dis_pkg::AGE_SAT) ? age_reg[i] + 10'h001
                                                                  : age_reg[i]);
         chat_next = win_end ? 8'h00 :
                     ((acc_vec[i] && chat_reg != dis_pkg::CHAT_SAT) ? chat_reg + 8'h01
                                                                    : chat_reg);
         // [R6] over the limit disables, set beats re-enable
         dis_next  = (chat_on && acc_vec[i] && chat_reg >= cfg_chat_limit) |
                     (chat_disabled[i] & ~chat_reenable[i]);
      end
      always_ff @(posedge clk) begin
         if (!nrst) begin
            age_reg[i]       <= 10'h000;
            chat_reg         <= 8'h00;
            chat_disabled[i] <= 1'b0;
         end else begin
            age_reg[i]       <= age_next;
            chat_reg         <= chat_next;
            chat_disabled[i] <= dis_next;
         end
      end
      if (i % 2 == 0) begin : g_pair
         logic [17:0] tmr_reg, tmr_next;
         always_comb begin
            // [R9] hold-off for double-bit reports
            tmr_next = dbl_load[i / 2] ?
                       18'(cfg_dbl_sec) * 18'(dis_pkg::MS_PER_S) :
                       ((ms_tick && tmr_reg != 18'h00000) ? tmr_reg - 18'h00001 : tmr_reg);
         end
         always_ff @(posedge clk) begin
            if (!nrst) begin
               tmr_reg <= 18'h00000;
            end else begin
               tmr_reg <= tmr_next;
            end
         end
         assign dbl_zero[i / 2] = (tmr_reg == 18'h00000);
      end
   end

   // current channel in the walk
   always_comb begin
      // [R3] inversion comes first
      raw   = field_in[idx_reg] ^ cfg_invert[idx_reg];
      mate  = field_in[idx_reg ^ 5'h01] ^ cfg_invert[idx_reg ^ 5'h01];
      ptype = dis_pkg::dis_ptype_type'(cfg_type[{idx_reg, 1'b0} +: 2]);
      form  = cfg_form[{idx_reg, 1'b0} +: 2];
      // [R4] per-channel debounce ms
      deb   = cfg_deb_ms[idx_reg * dis_pkg::DEB_W +: dis_pkg::DEB_W];
      pair  = idx_reg[4:1];
      // [R14] Form B is normally closed, Form C holds on a non-changeover
      if (ptype == dis_pkg::PT_COUNT && form == dis_pkg::FORM_B) begin
         raw = ~raw;
      end
      if (ptype == dis_pkg::PT_COUNT && form == dis_pkg::FORM_C && raw == mate) begin
         raw = point_level[idx_reg];
      end
      // [R17] stable for the full debounce time
      accept = (raw != point_level[idx_reg]) && !chat_disabled[idx_reg] &&
               (deb == 10'h000 || (raw == cand_reg[idx_reg] && age_reg[idx_reg] >= deb));
      // [R12] back-date to the first scan that saw the new level
      tag    = (raw == cand_reg[idx_reg]) ? ms_now - 32'(age_reg[idx_reg]) : ms_now;
      dnew   = {point_level[idx_reg ^ 5'h01], accept ? raw : point_level[idx_reg]};
   end

   // [R8] gather BCD-typed levels in channel order, decode eight digits
   always_comb begin
      bcd_bits     = 32'h0000_0000;
      bcd_acc      = 27'h000_0000;
      bcd_err_next = 1'b0;
      dig          = 4'h0;
      k            = 0;
      for (int i = 0; i < dis_pkg::NCH; i++) begin
         if (cfg_type[2 * i +: 2] == dis_pkg::PT_BCD) begin
            bcd_bits[k] = point_level[i];
            k           = k + 1;
         end
      end
      for (int d = dis_pkg::BCD_DIGITS - 1; d >= 0; d--) begin
         dig          = bcd_bits[4 * d +: 4];
         bcd_err_next = bcd_err_next | (dig > 4'h9);
         bcd_acc      = 27'(bcd_acc * 27'h000_000A + 27'(dig));
      end
   end

   always_comb begin
      st_next       = st_reg;
      idx_next      = idx_reg;
      lvl_next      = point_level;
      cand_next     = cand_reg;
      frz_pend_next = frz_pend_reg | cmd_freeze;
      clr_pend_next = clr_pend_reg | cmd_clear;
      frz_app_next  = frz_app_reg;
      clr_app_next  = clr_app_reg;
      pv_next       = 1'b0;
      pinc_next     = 1'b0;
      pidx_next     = idx_reg;
      evv_next      = 1'b0;
      evp_next      = ev_point;
      evk_next      = ev_kind;
      evs_next      = ev_state;
      evt_next      = ev_time;
      bcd_next      = bcd_value;
      age_clr       = 32'h0000_0000;
      acc_vec       = 32'h0000_0000;
      dbl_load      = 16'h0000;
      dbl_pend_next = dbl_pend_reg;
      dbl_last_next = dbl_last_reg;
      dbl_time_next = dbl_time_reg;
      case (st_reg)
         dis_pkg::W_IDLE: begin
            // [R2] one walk per scan tick, commands latched until then
            if (scan_tick) begin
               st_next       = dis_pkg::W_RUN;
               idx_next      = 5'h00;
               frz_app_next  = frz_pend_reg | cmd_freeze;
               clr_app_next  = clr_pend_reg | cmd_clear;
               frz_pend_next = 1'b0;
               clr_pend_next = 1'b0;
            end
         end
         dis_pkg::W_RUN: begin
            // [R1] all channels walked in one pass
            idx_next = idx_reg + 5'h01;
            if (idx_reg == dis_pkg::LAST_CH) begin
               st_next = dis_pkg::W_DRAIN;
            end
            pv_next = 1'b1;
            if (raw != cand_reg[idx_reg]) begin
               cand_next[idx_reg] = raw;
               age_clr[idx_reg]   = 1'b1;
            end
            if (accept) begin
               lvl_next[idx_reg] = raw;
               acc_vec[idx_reg]  = 1'b1;
               cand_next[idx_reg] = raw;
            end
            // [R7] per-type handling
            // [R10] single-bit event
            if (accept && ptype == dis_pkg::PT_SINGLE && cfg_event_en[idx_reg]) begin
               evv_next = 1'b1;
               evp_next = idx_reg;
               evk_next = dis_pkg::EV_SINGLE;
               evs_next = {1'b0, raw};
               evt_next = tag;
            end
            // [R15] rising only, or both edges
            if (accept && ptype == dis_pkg::PT_COUNT) begin
               pinc_next = raw | cfg_both_edges[idx_reg];
            end
            if (idx_reg[0] &&
                cfg_type[{idx_reg ^ 5'h01, 1'b0} +: 2] == dis_pkg::PT_DOUBLE) begin
               if (dnew != dbl_last_reg[pair]) begin
                  dbl_last_next[pair] = dnew;
                  dbl_pend_next[pair] = 1'b1;
                  dbl_load[pair]      = 1'b1;
                  dbl_time_next[pair] = accept ? tag : ms_now;
               end else if (dbl_pend_reg[pair] && dbl_zero[pair]) begin
                  // [R11] point, kind and time of the change
                  dbl_pend_next[pair] = 1'b0;
                  evv_next = cfg_event_en[idx_reg ^ 5'h01];
                  evp_next = idx_reg ^ 5'h01;
                  evk_next = dis_pkg::EV_DOUBLE;
                  evs_next = dbl_last_reg[pair];
                  evt_next = dbl_time_reg[pair];
               end
            end
         end
         dis_pkg::W_DRAIN: begin
            st_next      = dis_pkg::W_IDLE;
            bcd_next     = bcd_acc;
            frz_app_next = 1'b0;
            clr_app_next = 1'b0;
         end
         default: begin
            st_next = dis_pkg::W_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg       <= dis_pkg::W_IDLE;
         idx_reg      <= 5'h00;
         pidx_reg     <= 5'h00;
         point_level  <= 32'h0000_0000;
         cand_reg     <= 32'h0000_0000;
         frz_pend_reg <= 1'b0;
         clr_pend_reg <= 1'b1;
         frz_app_reg  <= 1'b0;
         clr_app_reg  <= 1'b0;
         pv_reg       <= 1'b0;
         pinc_reg     <= 1'b0;
         ev_valid     <= 1'b0;
         ev_point     <= 5'h00;
         ev_kind      <= dis_pkg::EV_SINGLE;
         ev_state     <= 2'h0;
         ev_time      <= dis_pkg::TIME_RST;
         bcd_value    <= 27'h000_0000;
         bcd_error    <= 1'b0;
         dbl_pend_reg <= 16'h0000;
         for (int p = 0; p < 16; p++) begin
            dbl_last_reg[p] <= 2'h0;
            dbl_time_reg[p] <= dis_pkg::TIME_RST;
         end
      end else begin
         st_reg       <= st_next;
         idx_reg      <= idx_next;
         pidx_reg     <= pidx_next;
         point_level  <= lvl_next;
         cand_reg     <= cand_next;
         frz_pend_reg <= frz_pend_next;
         clr_pend_reg <= clr_pend_next;
         frz_app_reg  <= frz_app_next;
         clr_app_reg  <= clr_app_next;
         pv_reg       <= pv_next;
         pinc_reg     <= pinc_next;
         ev_valid     <= evv_next;
         ev_point     <= evp_next;
         ev_kind      <= evk_next;
         ev_state     <= evs_next;
         ev_time      <= evt_next;
         bcd_value    <= bcd_next;
         bcd_error    <= (st_reg == dis_pkg::W_DRAIN) ? bcd_err_next : bcd_error;
         dbl_pend_reg <= dbl_pend_next;
         dbl_last_reg <= dbl_last_next;
         dbl_time_reg <= dbl_time_next;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   walk_len_a: assert property ($rose(st_reg == dis_pkg::W_RUN) |-> // [R1]
      ##31 (st_reg == dis_pkg::W_RUN) ##1 (st_reg == dis_pkg::W_DRAIN))
      else $error("walk did not cover 32 channels");
   scan_start_a: assert property ((st_reg == dis_pkg::W_IDLE && scan_tick) |=> // [R2]
      st_reg == dis_pkg::W_RUN && idx_reg == 5'h00)
      else $error("scan tick did not start a walk");
   debounce_hold_a: assert property ((st_reg == dis_pkg::W_RUN && accept && // [R17]
      deb != 10'h000) |-> raw == cand_reg[idx_reg] && age_reg[idx_reg] >= deb)
      else $error("level accepted before debounce time");
   accept_level_a: assert property ((st_reg == dis_pkg::W_RUN && accept) |=> // [R4]
      point_level[$past(idx_reg)] != $past(point_level[idx_reg]))
      else $error("accepted change not stored");
   chat_block_a: assert property ((st_reg == dis_pkg::W_RUN && // [R18]
      chat_disabled[idx_reg]) |-> !accept ##1 !pinc_reg)
      else $error("disabled input produced activity");
   dbl_wait_a: assert property ((evv_next && evk_next == dis_pkg::EV_DOUBLE) |-> // [R9]
      dbl_zero[pair])
      else $error("double report before hold-off");
   ev_walk_a: assert property (evv_next |-> st_reg == dis_pkg::W_RUN && // [R10]
      cfg_event_en[evp_next])
      else $error("event outside walk or not enabled");
   cnt_clear_a: assert property ((pv_reg && clr_app_reg) |-> // [R16]
      wd_live == 32'h0000_0000)
      else $error("clear did not zero counter");
   cnt_step_a: assert property ((pv_reg && !clr_app_reg) |-> // [R13]
      wd_live == rd_live + {31'h0, pinc_reg})
      else $error("counter step wrong");
endmodule
`default_nettype wire

// file: tb/dis_field_model.sv
`default_nettype none
module dis_field_model #(
   parameter int DLY = 1
) (
   // clock
   input  wire logic        clk,
   // contact positions asked by the bench
   input  wire logic [31:0] want,
   // wetted contact levels
   output logic      [31:0] field_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // relay pickup lag, so the scanner never sees a change in its own cycle
   logic [31:0] pipe [DLY] = '{default: 32'h0};
   always @(posedge clk) begin
      pipe[0] <= want;
      for (int i = 1; i < DLY; i++) begin
         pipe[i] <= pipe[i-1];
      end
   end
   assign field_in = pipe[DLY-1];
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 72;
   localparam int MC = 80;
   logic         clk = 1'b0;
   logic         nrst = 1'b0;
   logic [31:0]  want = 32'h0;
   logic [31:0]  field_in;
   logic [31:0]  cfg_invert = 32'h0;
   logic [63:0]  cfg_type = 64'h0;
   logic [63:0]  cfg_form = 64'h0;
   logic [31:0]  cfg_both_edges = 32'h0;
   logic [31:0]  cfg_event_en = 32'h0;
   logic [319:0] cfg_deb_ms = 320'h0;
   logic [7:0]   cfg_dbl_sec = 8'h0;
   logic [15:0]  cfg_chat_win_ms = 16'h0;
   logic [7:0]   cfg_chat_limit = 8'h02;
   logic [31:0]  chat_reenable = 32'h0;
   logic         cmd_freeze = 1'b0;
   logic         cmd_clear = 1'b0;
   logic [5:0]   cnt_rd_addr = 6'h0;
   logic [31:0]  cnt_rd_data, point_level, chat_disabled, ev_time;
   logic [26:0]  bcd_value;
   logic         bcd_error, ev_valid, ev_kind;
   logic [4:0]   ev_point;
   logic [1:0]   ev_state;
   int           err_count = 0;
   int           cmp_count = 0;
   int           cyc = 0;
   int           ev_total = 0;
   int           n0, t0;

   always #12.5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= nrst ? cyc + 1 : 0;
      if (ev_valid === 1'b1) ev_total <= ev_total + 1;
   end

   // slow contacts: several cycles of pickup lag
   dis_field_model #(.DLY(5)) contacts (.clk(clk), .want(want), .field_in(field_in));

   dis_scanner #(.SCAN_CYC(SC), .MS_CYC(MC)) DUT (
      .clk(clk), .nrst(nrst), .field_in(field_in), .cfg_invert(cfg_invert),
      .cfg_type(cfg_type), .cfg_form(cfg_form), .cfg_both_edges(cfg_both_edges),
      .cfg_event_en(cfg_event_en), .cfg_deb_ms(cfg_deb_ms), .cfg_dbl_sec(cfg_dbl_sec),
      .cfg_chat_win_ms(cfg_chat_win_ms), .cfg_chat_limit(cfg_chat_limit),
      .chat_reenable(chat_reenable), .cmd_freeze(cmd_freeze), .cmd_clear(cmd_clear),
      .cnt_rd_addr(cnt_rd_addr), .cnt_rd_data(cnt_rd_data), .point_level(point_level),
      .chat_disabled(chat_disabled), .bcd_value(bcd_value), .bcd_error(bcd_error),
      .ev_valid(ev_valid), .ev_point(ev_point), .ev_kind(ev_kind), .ev_state(ev_state),
      .ev_time(ev_time));

   task automatic conclude;
      if (err_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic rd_cnt(input logic [5:0] addr, input logic [31:0] exp);
      cnt_rd_addr = addr;
      step(2);
      check("counter", cnt_rd_data, exp);
   endtask

   // waits for the next event record and compares its fields
   task automatic wait_ev(input logic [4:0] pt, input logic k, input logic [1:0] st,
                          input logic chk_t);
      int i;
      int d;
      i = 0;
      while (ev_total == n0 && i < 2000) begin
         step(1);
         i++;
      end
      d = int'(ev_time) - t0;
      check("event seen", 32'(ev_total > n0), 32'h1);
      check("event point", 32'(ev_point), 32'(pt));
      check("event kind", 32'(ev_kind), 32'(k));
      check("event state", 32'(ev_state), 32'(st));
      if (chk_t) begin
         check("event time", 32'(d >= -1 && d <= 1), 32'h1);
         check("event latency", 32'(i <= SC + 12), 32'h1);
      end
   endtask

   task automatic pulse(input logic [31:0] m, input int w);
      want = want | m;
      step(w);
      want = want & ~m;
      step(w);
   endtask

   initial begin
      cfg_event_en = 32'h1010_0008;
      cfg_invert[5] = 1'b1;
      cfg_deb_ms[70 +: 10] = 10'd3;
      cfg_type[20 +: 6] = 6'h3F;
      cfg_both_edges[11] = 1'b1;
      cfg_form[24 +: 2] = dis_pkg::FORM_B;
      cfg_type[48 +: 8] = 8'hAA;
      cfg_type[56 +: 4] = 4'h5;
      step(6);
      nrst = 1'b1;
      step(3 * SC);
      check("inverted level", 32'(point_level[5]), 32'h1);
      // single point event, group one
      n0 = ev_total;
      t0 = cyc / MC;
      want[3] = 1'b1;
      wait_ev(5'd3, dis_pkg::EV_SINGLE, 2'b01, 1'b1);
      // a glitch shorter than the debounce time is dropped
      pulse(32'h80, 150);
      step(3 * SC);
      check("glitch level", 32'(point_level[7]), 32'h0);
      want[7] = 1'b1;
      step(150);
      check("early level", 32'(point_level[7]), 32'h0);
      step(350);
      check("debounced level", 32'(point_level[7]), 32'h1);
      // counters: form A rising, both edges, form B
      for (int p = 0; p < 3; p++) pulse(32'h1C00, 4 * MC);
      rd_cnt(6'd10, 32'd3);
      rd_cnt(6'd11, 32'd6);
      rd_cnt(6'd12, 32'd3);
      cmd_freeze = 1'b1;
      step(1);
      cmd_freeze = 1'b0;
      step(2 * SC);
      pulse(32'h400, 4 * MC);
      rd_cnt(6'd10, 32'd4);
      rd_cnt(6'h2A, 32'd3);
      cmd_clear = 1'b1;
      step(1);
      cmd_clear = 1'b0;
      step(2 * SC);
      rd_cnt(6'd11, 32'd0);
      rd_cnt(6'h2A, 32'd3);
      // BCD digit on channels 24..27
      want[27:24] = 4'h7;
      step(3 * SC);
      check("bcd value", 32'(bcd_value), 32'h7);
      check("bcd error", 32'(bcd_error), 32'h0);
      want[27:24] = 4'hA;
      step(3 * SC);
      check("bcd error", 32'(bcd_error), 32'h1);
      // double point 28/29, group two
      n0 = ev_total;
      want[28] = 1'b1;
      wait_ev(5'd28, dis_pkg::EV_DOUBLE, 2'b10, 1'b0);
      check("double level", 32'(point_level[28]), 32'h1);
      // chatter on channel 20
      cfg_chat_win_ms = 16'd50;
      for (int p = 0; p < 3; p++) pulse(32'h10_0000, 2 * SC);
      check("chatter flag", 32'(chat_disabled[20]), 32'h1);
      n0 = ev_total;
      pulse(32'h10_0000, 2 * SC);
      check("muted events", 32'(ev_total), 32'(n0));
      chat_reenable[20] = 1'b1;
      step(1);
      chat_reenable[20] = 1'b0;
      step(2);
      check("reenabled", 32'(chat_disabled[20]), 32'h0);
      conclude();
   end

   // whole sequence needs roughly 6000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule
`default_nettype wire
